// >>> verilog/wwd_map.vh
// timing constants for the wakeup/watchdog reset supervisor
`ifndef WWD_MAP_VH
`define WWD_MAP_VH
// ============================================================
// timing: one unit of the timing resistor scale
`define WWD_TICK_NS 5000
`define WWD_CLK_NS 10
`define WWD_TICK_CYC (`WWD_TICK_NS / `WWD_CLK_NS)
// ============================================================
// interval lengths in ticks
`define WWD_RST_DELAY_TICKS 1
`define WWD_WAKE_DELAY_TICKS 4
`define WWD_PERIOD_TICKS 8
`define WWD_HALF_TICKS 4
`endif

// >>> verilog/wwd_supervisor.v
// wakeup, watchdog and reset supervisor logic of a regulator
// Notes on behaviour
// R1: hold reset low until output regulates
// R2: undervoltage resets; release after recovery plus delay
// R3: reset when no watchdog edge per period
// R4: input-supply low forces reset regardless
// R5: wakeup held low while reset asserted
// R6: after release, first wakeup after delay
// R7: wakeup period is eight tick units
// R8: reset delay is one tick unit
// R9: reset-to-wakeup delay is four units
// R10: enable low shuts down pass stage
// R11: wakeup is a 50 percent square wave
// R12: first watchdog falling edge forces wakeup low
// R13: later watchdog edges in cycle ignored
// R14: missed watchdog resets at cycle end
// R15: all intervals derive from one tick
`timescale 1ns/1ns
`include "wwd_map.vh"
module wwd_supervisor #(
  parameter TICK_CYC = `WWD_TICK_CYC
) (
  // clock and reset
  input wire MCLK,
  input wire RST_N,
  // supervisor inputs from pins and comparators
  input wire ENABLE,
  input wire OUT_IN_REG,
  input wire IN_SUPPLY_LOW,
  input wire WATCHDOG_PULSE_IN,
  // outputs
  output reg RESET_OUT_N,
  output reg WAKEUP_OUT,
  output reg PASS_ON
);
  // ============================================================
  // states
  localparam [2:0] ST_OFF = 3'h0;
  localparam [2:0] ST_HOLD = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_WAKE_WAIT = 3'h3;
  localparam [2:0] ST_RUN = 3'h4;
  localparam [3:0] RST_TICKS = `WWD_RST_DELAY_TICKS;
  localparam [3:0] WAKE_TICKS = `WWD_WAKE_DELAY_TICKS;
  localparam [3:0] PER_TICKS = `WWD_PERIOD_TICKS;
  localparam [3:0] HALF_TICKS = `WWD_HALF_TICKS;
  localparam [31:0] TICK_LAST = TICK_CYC - 1;

  // bit positions of the pins in the synchroniser bank
  localparam PIN_EN = 0;
  localparam PIN_VOUT = 1;
  localparam PIN_VIN = 2;
  localparam PIN_WDOG = 3;
  localparam PIN_COUNT = 4;

  // ============================================================
  // reset release
  reg rst_s1_reg;
  reg rst_n_reg;
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg <= rst_s1_reg;
    end
  end

  // ============================================================
  // input synchronisers, one generate per pin
  // comparator and pin levels are asynchronous, so each passes two flops
  wire [3:0] pin_raw;
  wire [3:0] pin_sync;
  assign pin_raw = {WATCHDOG_PULSE_IN, IN_SUPPLY_LOW, OUT_IN_REG, ENABLE};
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_sync
      reg s1_reg;
      reg s2_reg;
      always @(posedge MCLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
        end else begin
          s1_reg <= pin_raw[gi];
          s2_reg <= s1_reg;
        end
      end
      assign pin_sync[gi] = s2_reg;
    end
  endgenerate
  wire en_s;
  wire vout_ok_s;
  wire vin_low_s;
  wire wdog_s;
  assign en_s = pin_sync[PIN_EN];
  assign vout_ok_s = pin_sync[PIN_VOUT];
  assign vin_low_s = pin_sync[PIN_VIN];
  assign wdog_s = pin_sync[PIN_WDOG];

  // ============================================================
  // watchdog falling edge, taken from the synchronised copy only
  // the edge register starts low, so the idle-high pin gives no false fall
  reg wdog_prev_reg;
  always @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wdog_prev_reg <= 1'b0;
    end else begin
      wdog_prev_reg <= wdog_s;
    end
  end
  wire wdog_fall = wdog_prev_reg & ~wdog_s;

  // ============================================================
  // tick prescaler: every interval is a whole number of ticks
  // limitation: the resistor scale is only as fine as one tick of TICK_CYC clocks
  reg [31:0] pre_reg;
  wire tick = (pre_reg == TICK_LAST); // R15
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [3:0] tcnt_reg;
  reg [3:0] tcnt_next;
  reg wd_seen_reg;
  reg wd_seen_next;
  wire restart = (state_reg != state_next);
  always @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pre_reg <= 32'h0;
    end else if (tick || restart) begin
      pre_reg <= 32'h0;
    end else begin
      pre_reg <= pre_reg + 32'h1;
    end
  end

  // fault sources that must pull reset low right away
  // enable low still wins over every fault, by the override below
  wire fault = ~vout_ok_s | vin_low_s; // R2 R4

  // ============================================================
  // decoding shared by the state, counter and output logic
  // tick count that closes an interval of len ticks
  function interval_end;
    input [3:0] cnt;
    input [3:0] len;
    begin
      interval_end = (cnt == len - 4'h1);
    end
  endfunction

  // length in ticks of the interval a timed state runs for
  function [3:0] interval_len;
    input [2:0] st;
    begin
      case (st)
        ST_DELAY: interval_len = RST_TICKS; // R8
        ST_WAKE_WAIT: interval_len = WAKE_TICKS; // R9
        ST_RUN: interval_len = PER_TICKS; // R7
        default: interval_len = 4'h1;
      endcase
    end
  endfunction

  // reset pin is high only once the release delay has run out
  function reset_released;
    input [2:0] st;
    begin
      reset_released = (st == ST_WAKE_WAIT) || (st == ST_RUN);
    end
  endfunction

  // the tick that closes the running interval
  wire span_end = tick && interval_end(tcnt_reg, interval_len(state_reg));

  // ============================================================
  // supervisor state machine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (en_s) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // stay low until the output regulates and input is adequate
        if (!fault) begin
          state_next = ST_DELAY; // R1 R2
        end
      end
      ST_DELAY: begin
        if (fault) begin
          state_next = ST_HOLD; // R2
        end else if (span_end) begin
          state_next = ST_WAKE_WAIT; // R8
        end
      end
      ST_WAKE_WAIT: begin
        if (fault) begin
          state_next = ST_HOLD; // R4
        end else if (span_end) begin
          state_next = ST_RUN; // R6 R9
        end
      end
      ST_RUN: begin
        if (fault) begin
          state_next = ST_HOLD; // R2 R4
        end else if (span_end && !wd_seen_reg && !wdog_fall) begin
          // missing edge is judged only at the cycle's end
          state_next = ST_DELAY; // R3 R14
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
    if (!en_s) begin
      state_next = ST_OFF; // R10
    end
  end

  // ============================================================
  // tick counter within the current interval
  always @* begin
    tcnt_next = tcnt_reg;
    case (state_reg)
      ST_DELAY, ST_WAKE_WAIT, ST_RUN: begin
        // a fault leaves the count alone; the hold state clears it
        if (!fault && tick) begin
          if (span_end) begin
            tcnt_next = 4'h0;
          end else begin
            tcnt_next = tcnt_reg + 4'h1; // R7
          end
        end
      end
      default: begin
        tcnt_next = 4'h0;
      end
    endcase
    if (!en_s) begin
      tcnt_next = 4'h0;
    end
  end

  // ============================================================
  // watchdog edge seen in the current wakeup cycle
  always @* begin
    wd_seen_next = wd_seen_reg;
    case (state_reg)
      ST_WAKE_WAIT: begin
        wd_seen_next = 1'b0;
      end
      ST_RUN: begin
        if (wdog_fall) begin
          wd_seen_next = 1'b1; // R12 R13
        end
        // the cycle's end clears it for the next cycle
        if (!fault && span_end) begin
          wd_seen_next = 1'b0;
        end
      end
      default: begin
        wd_seen_next = wd_seen_reg;
      end
    endcase
  end

  always @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_OFF;
      tcnt_reg <= 4'h0;
      wd_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tcnt_reg <= tcnt_next;
      wd_seen_reg <= wd_seen_next;
    end
  end

  // ============================================================
  // registered outputs
  // decoded from the next state so each pin comes straight from a flop
  wire run_next = (state_next == ST_RUN);
  wire wake_half = (tcnt_next < HALF_TICKS); // R11
  // low during reset and once the cycle's watchdog edge arrived
  wire wake_next = run_next && wake_half && !wd_seen_next; // R5 R11 R12
  wire pass_next = (state_next != ST_OFF); // R10
  wire rst_out_next = reset_released(state_next); // R1 R2 R3 R4

  always @(posedge MCLK or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      RESET_OUT_N <= 1'b0;
      WAKEUP_OUT <= 1'b0;
      PASS_ON <= 1'b0;
    end else begin
      PASS_ON <= pass_next; // R10
      RESET_OUT_N <= rst_out_next; // R1 R2 R3 R4
      WAKEUP_OUT <= wake_next; // R5 R11 R12
    end
  end
endmodule

// >>> sim/wwd_monitor.sv
// assertion checker for the supervisor ports
`timescale 1ns/1ns
module wwd_monitor #(parameter TICK_CYC = 4) (
  // clock and reset
  input wire MCLK,
  input wire RST_N,
  // inputs
  input wire ENABLE,
  input wire OUT_IN_REG,
  input wire IN_SUPPLY_LOW,
  input wire WATCHDOG_PULSE_IN,
  // outputs
  input wire RESET_OUT_N,
  input wire WAKEUP_OUT,
  input wire PASS_ON
);
  // ==========
  // checks
  wire ok = ENABLE && OUT_IN_REG && !IN_SUPPLY_LOW;
  reg [15:0] hi_cnt_reg;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) hi_cnt_reg <= 16'h0000;
    else hi_cnt_reg <= WAKEUP_OUT ? hi_cnt_reg + 16'h0001 : 16'h0000;
  end
  wake_in_rst_a: assert property (!RESET_OUT_N && $past(!RESET_OUT_N) |-> !WAKEUP_OUT)
    else $error("wakeup high in reset");
  uv_rst_a: assert property ((!OUT_IN_REG)[*6] |-> !RESET_OUT_N)
    else $error("no reset on undervoltage");
  supply_rst_a: assert property (IN_SUPPLY_LOW[*6] |-> !RESET_OUT_N)
    else $error("no reset on supply low");
  shut_off_a: assert property ((!ENABLE)[*6] |-> !PASS_ON && !RESET_OUT_N)
    else $error("not shut down");
  pass_on_a: assert property (ENABLE[*8] |-> PASS_ON)
    else $error("pass stage off");
  release_ok_a: assert property ($rose(RESET_OUT_N) |-> $past(ok, 3))
    else $error("early release");
  wd_low_a: assert property ($fell(WATCHDOG_PULSE_IN) && WAKEUP_OUT |-> ##[1:6] !WAKEUP_OUT)
    else $error("watchdog ignored");
  half_len_a: assert property (hi_cnt_reg <= 4 * TICK_CYC)
    else $error("wakeup high too long");
  end_cycle_a: assert property (ok[*8] ##0 $fell(RESET_OUT_N) |-> !$past(WAKEUP_OUT, 8))
    else $error("reset mid cycle");
  cover property (ok && $fell(RESET_OUT_N));
  cover property ($rose(WAKEUP_OUT));
  cover property ($fell(WATCHDOG_PULSE_IN) && WAKEUP_OUT);
endmodule
bind wwd_supervisor wwd_monitor #(.TICK_CYC(TICK_CYC)) mon (.MCLK(MCLK), .RST_N(RST_N),
  .ENABLE(ENABLE), .OUT_IN_REG(OUT_IN_REG), .IN_SUPPLY_LOW(IN_SUPPLY_LOW),
  .WATCHDOG_PULSE_IN(WATCHDOG_PULSE_IN), .RESET_OUT_N(RESET_OUT_N),
  .WAKEUP_OUT(WAKEUP_OUT), .PASS_ON(PASS_ON));

// >>> sim/wwd_mcu.sv
// controller model answering wakeup with watchdog pulses
`timescale 1ns/1ns
module wwd_mcu (
  // clock and controls
  input wire clk,
  input wire wake,
  input wire mute,
  input wire [3:0] dly,
  // watchdog line
  output reg wdog
);
  // ==========
  // two falls per wakeup: the second must be ignored
  reg wake_d_reg;
  integer cnt;
  initial begin
    wdog = 1'b1;
    wake_d_reg = 1'b0;
    cnt = 99;
  end
  always @(posedge clk) begin
    wake_d_reg <= wake;
    cnt <= (wake && !wake_d_reg) ? 0 : cnt + 1;
    wdog <= mute || (cnt != dly && cnt != dly + 3);
  end
endmodule

// >>> sim/wakeup_watchdog_reset_supervisor_test.sv
// self-checking bench for the supervisor
`timescale 1ns/1ns
module wakeup_watchdog_reset_supervisor_test;
  // ==========
  // bench
  localparam T = 4;
  reg MCLK, RST_N, ENABLE, OUT_IN_REG, IN_SUPPLY_LOW, mute;
  reg [3:0] dly;
  reg [15:0] seed;
  wire WATCHDOG_PULSE_IN, RESET_OUT_N, WAKEUP_OUT, PASS_ON;
  wire [1:0] o = {RESET_OUT_N, WAKEUP_OUT};
  integer n_errors, n_checks, n, i, len;
  // rule model: expected durations queued per scenario, in bench clocks
  integer exp_q[$];
  integer exp_v;
  wwd_supervisor #(.TICK_CYC(T)) uut (.MCLK(MCLK), .RST_N(RST_N), .ENABLE(ENABLE),
    .OUT_IN_REG(OUT_IN_REG), .IN_SUPPLY_LOW(IN_SUPPLY_LOW),
    .WATCHDOG_PULSE_IN(WATCHDOG_PULSE_IN), .RESET_OUT_N(RESET_OUT_N),
    .WAKEUP_OUT(WAKEUP_OUT), .PASS_ON(PASS_ON));
  wwd_mcu mcu (.clk(MCLK), .wake(WAKEUP_OUT), .mute(mute), .dly(dly), .wdog(WATCHDOG_PULSE_IN));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        n_errors = n_errors + 1;
      end
    end
  endtask
  // units: reset delay 1, wakeup delay 4, period 8 ticks of T clocks
  function integer model_cycles(input integer ticks);
    model_cycles = ticks * T;
  endfunction
  task chk_dur(input [31:0] got);
    begin
      exp_v = exp_q.pop_front();
      chk(got, exp_v);
    end
  endtask
  // counts falling edges until an output reaches a level, bounded
  task wt(input integer k, input v);
    begin
      n = 0;
      while (o[k] !== v && n < 500) begin
        @(negedge MCLK);
        n = n + 1;
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  initial begin
    #30000;
    n_errors = n_errors + 1;
    final_report;
  end
  initial begin
    n_errors = 0;
    n_checks = 0;
    {RST_N, ENABLE, OUT_IN_REG, IN_SUPPLY_LOW, mute, dly, seed} = {5'h0C, 4'h3, 16'hC157};
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    @(negedge MCLK);
    wt(1, 1);
    exp_q.push_back(model_cycles(4));
    wt(0, 1);
    chk_dur(n);
    repeat (3) begin
      seed = lfsr(seed);
      @(posedge MCLK) dly <= 4'h1 + seed[2:0];
      wt(0, 1);
      wt(0, 0);
      chk({o[1], n < 4 * T}, 2'h3);
    end
    $display("test 1 done");
    @(posedge MCLK) mute <= 1'b1;
    exp_q.push_back(model_cycles(8));
    exp_q.push_back(model_cycles(1));
    exp_q.push_back(model_cycles(4));
    wt(0, 1);
    wt(1, 0);
    chk_dur(n);
    wt(1, 1);
    chk_dur(n);
    @(posedge MCLK) mute <= 1'b0;
    wt(0, 1);
    chk_dur(n);
    $display("test 2 done");
    for (i = 0; i < 3; i = i + 1) begin
      seed = lfsr(seed);
      len = 8 + seed[3:0];
      @(posedge MCLK) {OUT_IN_REG, IN_SUPPLY_LOW, ENABLE} <= {i != 0, i == 1, i != 2};
      repeat (len) @(posedge MCLK);
      @(negedge MCLK);
      chk({o, PASS_ON}, {2'h0, i != 2});
      @(posedge MCLK) {OUT_IN_REG, IN_SUPPLY_LOW, ENABLE} <= 3'h5;
      @(negedge MCLK);
      wt(1, 1);
      chk(n > T, 1);
      exp_q.push_back(model_cycles(4));
      wt(0, 1);
      chk_dur(n);
      $display("test 3.%0d done", i);
    end
    final_report;
  end
endmodule
